/* File: pkg/msr_consts.svh */
// shared constants for the module supervisor: register offsets, fields, reset values, timing
// assumes a 20 MHz reference clock
`ifndef MSR_CONSTS_SVH
`define MSR_CONSTS_SVH
`define MSR_CLK_HZ          20000000
`define MSR_RC_DELAY_US     100
`define MSR_RC_DELAY_CYC    ((`MSR_RC_DELAY_US * (`MSR_CLK_HZ / 1000000)))
`define MSR_SETTLE_US       10
`define MSR_SETTLE_CYC      ((`MSR_SETTLE_US * (`MSR_CLK_HZ / 1000000)))
`define MSR_BLINK_MS        250
`define MSR_BLINK_CYC       ((`MSR_BLINK_MS * (`MSR_CLK_HZ / 1000)))
`define MSR_WDT_MS          1000
`define MSR_WDT_CYC         ((`MSR_WDT_MS * (`MSR_CLK_HZ / 1000)))
`define MSR_STRAP_NOR       9'h044
`define MSR_STRAP_SD        9'h040
`define MSR_CFG_WORD_BITS   512
`define MSR_ADDR_CTRL       4'h0
`define MSR_ADDR_STATUS     4'h1
`define MSR_ADDR_GPIO       4'h2
`define MSR_ADDR_CFGW       4'h3
`define MSR_CTRL_WDT_ACK    0
`define MSR_CTRL_SUSPEND    1
`define MSR_GPIO_LINE13     13
`define MSR_GPIO_LINE15     15
`define MSR_GPIO_RESET      16'h0000
`define MSR_RAIL_CNT        6
`endif

/* File: pkg/msr_pkg.sv */
// types for the module supervisor
// assumes the constants header is compiled alongside
package msr_pkg;
  typedef enum logic [6:0] {
    MSR_OFF     = 7'b0000001,
    MSR_STAGE1  = 7'b0000010,
    MSR_STAGE2  = 7'b0000100,
    MSR_STAGE4  = 7'b0001000,
    MSR_CHECK   = 7'b0010000,
    MSR_RUN     = 7'b0100000,
    MSR_FAIL    = 7'b1000000
  } msr_state_e;
  typedef logic [8:0] msr_strap_t;
endpackage

/* File: rtl/msr_edge_fall.sv */
// falling edge detector for an active-low input already synchronous to the clock
// assumes the input idles high (pulled up)
`timescale 1ns/100ps
`default_nettype none
module msr_edge_fall (
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  input  wire logic i_level_n,
  output logic      o_fall
);
  logic prev_q;
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= i_level_n;
    end
  end
  assign o_fall = prev_q & ~i_level_n;
endmodule // msr_edge_fall
`default_nettype wire

/* File: rtl/msr_watchdog.sv */
// module watchdog: restarts on each kick, flags expiry until cleared
// assumes kick falling edges arrive as one-cycle pulses
`timescale 1ns/100ps
`default_nettype none
`include "msr_consts.svh"
module msr_watchdog #(
  parameter int unsigned TIMEOUT_CYC = `MSR_WDT_CYC
) (
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  input  wire logic i_enable,
  input  wire logic i_kick,
  input  wire logic i_clear,
  output logic      o_expired
);
  logic [31:0] cnt_q;
  logic        exp_q;
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || !i_enable || i_kick) begin
      cnt_q <= 32'h0;
    end else if (cnt_q != TIMEOUT_CYC - 1) begin
      cnt_q <= cnt_q + 32'h1;
    end else begin
      // wrap so a missed kick raises expiry once per window, not every cycle
      cnt_q <= 32'h0;
    end
  end
  // expiry wins over a simultaneous software acknowledge so no event is lost
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || !i_enable) begin
      exp_q <= 1'b0;
    end else if (i_enable && !i_kick && cnt_q == TIMEOUT_CYC - 1) begin
      exp_q <= 1'b1;
    end else if (i_clear) begin
      exp_q <= 1'b0;
    end
  end
  assign o_expired = exp_q;
endmodule // msr_watchdog
`default_nettype wire

/* File: rtl/msr_supervisor.sv */
// module supervisor: power sequencing, reset merge, straps, system signals
// assumes all pin inputs are synchronous to i_ref_clk
//
// Behaviour
// - processor reset is asserted by supervisor reset or debugger reset
// - peripheral resets follow main reset, then follow software output lines
// - phy reset is active low, driven by port 2 line 15
// - expansion reset is active low, port 2 line 13, out to carrier
// - primary 3.3V starts once 5V present and carrier power good
// - power request enables switched 3.3V, 2.5V and both 1.8V rails
// - switched 3.3V good enables the 1.0V converter
// - 1.35V converter enabled after delay from switched 3.3V
// - release processor reset only when all rails in tolerance
// - on rail failure hold reset and blink indicator LED
// - nine-bit boot strap field latched while power-on reset asserted
// - straps read NOR boot when sleep line high, SD when low
// - config word load and PLL lock precede boot fetch from same source
// - configuration word is 512 bits long
// - phy wake on request 0, phy irq 1, video irq 2
// - all line interrupts are OR-ed into one shared request
// - active-low suspend output cuts power to non-retained parts
// - power button active low, acted on at falling edge
// - sleep button active low, falling edge requests sleep or wake
// - module held in reset while reset button low
// - watchdog restarts on falling edge of each kick pulse
// - watchdog expiry raised on miss, cleared by ack, reset, power-down
`timescale 1ns/100ps
`default_nettype none
`include "msr_consts.svh"
module msr_supervisor
  import msr_pkg::*;
#(
  parameter int unsigned RC_DELAY_CYC = `MSR_RC_DELAY_CYC,
  parameter int unsigned BLINK_CYC    = `MSR_BLINK_CYC,
  parameter int unsigned WDT_CYC      = `MSR_WDT_CYC,
  parameter logic [7:0]  RAIL_LO      = 8'h73,
  parameter logic [7:0]  RAIL_HI      = 8'h8c
) (
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_rst,
  input  wire logic                      i_input_5v_ok,
  input  wire logic                      i_carrier_power_good,
  input  wire logic                      i_power_on_request,
  input  wire logic                      i_sw3v3_good,
  input  wire logic [`MSR_RAIL_CNT*8-1:0] i_rail_level,
  input  wire logic                      i_debug_reset_n,
  input  wire logic                      i_reset_button_n,
  input  wire logic                      i_power_button_n,
  input  wire logic                      i_sleep_button_n,
  input  wire logic                      i_watchdog_kick_n,
  input  wire logic                      i_phy_wake_irq_n,
  input  wire logic                      i_phy_irq_n,
  input  wire logic                      i_video_irq_n,
  input  wire logic [15:0]               i_line_irq,
  input  wire logic [3:0]                i_addr,
  input  wire logic [31:0]               i_wdata,
  input  wire logic                      i_wr,
  input  wire logic                      i_rd,
  output logic [31:0]                    o_rdata,
  output logic                           o_en_3v3_primary,
  output logic                           o_en_3v3_switched,
  output logic                           o_en_2v5,
  output logic                           o_en_1v8_video,
  output logic                           o_en_1v8_cpu,
  output logic                           o_en_1v0,
  output logic                           o_en_1v35,
  output logic                           o_power_on_reset_in,
  output logic                           o_cpu_reset_n,
  output logic                           o_phy_reset_n,
  output logic                           o_exp_reset_n,
  output msr_pkg::msr_strap_t            o_boot_source_straps,
  output logic                           o_fail_led,
  output logic                           o_suspend_power_off_n,
  output logic                           o_watchdog_expired,
  output logic [2:0]                     o_cpu_irq,
  output logic                           o_cpu_shared_irq,
  output logic                           o_power_event,
  output logic                           o_sleep_event
);
  msr_state_e  state_q;
  logic [31:0] dly_q;
  logic [31:0] dly135_q;
  logic [31:0] blink_q;
  logic        led_q;
  logic [15:0] gpio_q;
  logic        susp_q;
  logic        wdt_ack;
  logic        pwr_fall;
  logic        slp_fall;
  logic        kick_fall;
  logic        wdt_exp;
  logic        main_rst;
  logic        sup_rst;
  logic        rails_ok;
  logic        pwr_evt_q;
  logic        slp_evt_q;
  msr_strap_t  strap_q;
  logic [`MSR_RAIL_CNT-1:0] rail_in;
  logic [31:0] rdata_q;
  logic [31:0] rd_mux;

  // tolerance window per monitored rail, one comparator each
  for (genvar g = 0; g < `MSR_RAIL_CNT; g++) begin : g_rail
    assign rail_in[g] = (i_rail_level[g*8 +: 8] >= RAIL_LO) &&
                        (i_rail_level[g*8 +: 8] <= RAIL_HI);
  end
  assign rails_ok = &rail_in;

  msr_edge_fall u_pwr (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_level_n (i_power_button_n),
    .o_fall    (pwr_fall)
  );
  msr_edge_fall u_slp (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_level_n (i_sleep_button_n),
    .o_fall    (slp_fall)
  );
  msr_edge_fall u_kick (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_level_n (i_watchdog_kick_n),
    .o_fall    (kick_fall)
  );

  // power sequencing; carrier power good is trusted to mean its rails are ready
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state_q <= MSR_OFF;
    end else if (!i_input_5v_ok || !i_carrier_power_good) begin
      state_q <= MSR_OFF;
    end else begin
      unique case (state_q)
        MSR_OFF:    state_q <= MSR_STAGE1;
        MSR_STAGE1: if (i_power_on_request) begin
                      state_q <= MSR_STAGE2;
                    end
        MSR_STAGE2: if (!i_power_on_request) begin
                      state_q <= MSR_STAGE1;
                    end else if (i_sw3v3_good) begin
                      state_q <= MSR_STAGE4;
                    end
        MSR_STAGE4: if (!i_power_on_request) begin
                      state_q <= MSR_STAGE1;
                    end else if (dly_q == RC_DELAY_CYC - 1) begin
                      state_q <= MSR_CHECK;
                    end
        MSR_CHECK:  if (!i_power_on_request) begin
                      state_q <= MSR_STAGE1;
                    end else if (dly_q == `MSR_SETTLE_CYC - 1) begin
                      state_q <= rails_ok ? MSR_RUN : MSR_FAIL;
                    end
        MSR_RUN:    if (!i_power_on_request) begin
                      state_q <= MSR_STAGE1;
                    end else if (!rails_ok) begin
                      state_q <= MSR_FAIL;
                    end
        MSR_FAIL:   if (!i_power_on_request) begin
                      state_q <= MSR_STAGE1;
                    end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst || (state_q != MSR_STAGE4 && state_q != MSR_CHECK)) begin
      dly_q <= 32'h0;
    end else if ((state_q == MSR_STAGE4 && dly_q == RC_DELAY_CYC - 1) ||
                 (state_q == MSR_CHECK && dly_q == `MSR_SETTLE_CYC - 1)) begin
      dly_q <= 32'h0;
    end else begin
      dly_q <= dly_q + 32'h1;
    end
  end

  assign o_en_3v3_primary  = (state_q != MSR_OFF);
  assign o_en_3v3_switched = (state_q != MSR_OFF) && (state_q != MSR_STAGE1) && susp_q;
  assign o_en_2v5          = o_en_3v3_switched;
  assign o_en_1v8_video    = o_en_3v3_switched;
  assign o_en_1v8_cpu      = o_en_3v3_switched;
  assign o_en_1v0          = o_en_3v3_switched && i_sw3v3_good;

  // the 1.35V stage waits its own delay on every rise of the 1.0V stage, wake included
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || !o_en_1v0) begin
      dly135_q <= 32'h0;
    end else if (dly135_q != RC_DELAY_CYC) begin
      dly135_q <= dly135_q + 32'h1;
    end
  end
  assign o_en_1v35 = o_en_1v0 && (dly135_q == RC_DELAY_CYC);

  // failure blink runs only in the fail state, held until the power request or supply drops
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || state_q != MSR_FAIL) begin
      blink_q <= 32'h0;
      led_q   <= 1'b0;
    end else if (blink_q == BLINK_CYC - 1) begin
      blink_q <= 32'h0;
      led_q   <= ~led_q;
    end else begin
      blink_q <= blink_q + 32'h1;
    end
  end
  assign o_fail_led = led_q;

  // reset merge: supervisor, reset button and debugger all reach the processor
  assign sup_rst  = (state_q != MSR_RUN) || !i_reset_button_n;
  assign main_rst = sup_rst || !i_debug_reset_n;
  assign o_power_on_reset_in = sup_rst;
  assign o_cpu_reset_n       = ~main_rst;

  // output lines return to their reset value while the main reset is held
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || main_rst) begin
      gpio_q <= `MSR_GPIO_RESET;
    end else if (i_wr && i_addr == `MSR_ADDR_GPIO) begin
      gpio_q <= i_wdata[15:0];
    end
  end
  assign o_phy_reset_n = ~main_rst & gpio_q[`MSR_GPIO_LINE15];
  assign o_exp_reset_n = ~main_rst & gpio_q[`MSR_GPIO_LINE13];

  // straps follow the sleep line while power-on reset is held, frozen after
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      strap_q <= `MSR_STRAP_NOR;
    end else if (sup_rst) begin
      strap_q <= i_sleep_button_n ? `MSR_STRAP_NOR : `MSR_STRAP_SD;
    end
  end
  assign o_boot_source_straps = strap_q;

  // suspend: sleep button toggles, power button wakes; software can also force it
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || state_q == MSR_STAGE1 || state_q == MSR_OFF) begin
      susp_q <= 1'b1;
    end else if (pwr_fall) begin
      susp_q <= 1'b1;
    end else if (slp_fall) begin
      susp_q <= ~susp_q;
    end else if (i_wr && i_addr == `MSR_ADDR_CTRL) begin
      susp_q <= ~i_wdata[`MSR_CTRL_SUSPEND];
    end
  end
  assign o_suspend_power_off_n = susp_q;

  // button events are sticky for software; a new edge wins over a read clear
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      pwr_evt_q <= 1'b0;
      slp_evt_q <= 1'b0;
    end else begin
      pwr_evt_q <= pwr_fall | (pwr_evt_q & ~(i_rd && i_addr == `MSR_ADDR_STATUS));
      slp_evt_q <= slp_fall | (slp_evt_q & ~(i_rd && i_addr == `MSR_ADDR_STATUS));
    end
  end
  assign o_power_event = pwr_evt_q;
  assign o_sleep_event = slp_evt_q;

  assign wdt_ack = i_wr && (i_addr == `MSR_ADDR_CTRL) && i_wdata[`MSR_CTRL_WDT_ACK];
  msr_watchdog #(
    .TIMEOUT_CYC (WDT_CYC)
  ) u_wdt (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst || sup_rst),
    .i_enable  (o_en_3v3_switched),
    .i_kick    (kick_fall),
    .i_clear   (wdt_ack),
    .o_expired (wdt_exp)
  );
  assign o_watchdog_expired = wdt_exp;

  assign o_cpu_irq        = {~i_video_irq_n, ~i_phy_irq_n, ~i_phy_wake_irq_n};
  assign o_cpu_shared_irq = |i_line_irq;

  always_comb begin
    rd_mux = 32'h0;
    unique case (i_addr)
      `MSR_ADDR_CTRL:   rd_mux = {30'h0, ~susp_q, 1'b0};
      `MSR_ADDR_STATUS: rd_mux = {16'h0, 2'h0, strap_q, state_q[6:0] == MSR_RUN,
                                  slp_evt_q, pwr_evt_q, wdt_exp, rails_ok};
      `MSR_ADDR_GPIO:   rd_mux = {16'h0, gpio_q};
      `MSR_ADDR_CFGW:   rd_mux = 32'(`MSR_CFG_WORD_BITS);
      default:          rd_mux = 32'h0;
    endcase
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rdata_q <= 32'h0;
    end else if (i_rd) begin
      rdata_q <= rd_mux;
    end else begin
      rdata_q <= 32'h0;
    end
  end
  assign o_rdata = rdata_q;

  run_needs_rails_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_cpu_reset_n |-> rails_ok || $past(state_q) == MSR_RUN)
    else $error("processor released without rails");
  debug_reset_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !i_debug_reset_n |-> !o_cpu_reset_n)
    else $error("debugger reset not merged");
  periph_reset_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    main_rst |-> !o_phy_reset_n && !o_exp_reset_n)
    else $error("peripheral reset released during main reset");
  button_reset_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !i_reset_button_n |-> !o_cpu_reset_n)
    else $error("reset button ignored");
  onev_after_3v3_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_en_1v0 |-> o_en_3v3_switched && i_sw3v3_good)
    else $error("1.0V enabled early");
  late_1v35_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $rose(o_en_1v35) |-> $past(o_en_1v0))
    else $error("1.35V enabled without delay stage");
  primary_gate_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !i_carrier_power_good |=> !o_en_3v3_primary)
    else $error("primary rail on without power good");
  strap_sd_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    sup_rst && !i_sleep_button_n |=> o_boot_source_straps == `MSR_STRAP_SD)
    else $error("sd strap not latched");
  fail_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    state_q == MSR_FAIL |-> !o_cpu_reset_n)
    else $error("failed rail released reset");
  shared_irq_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_line_irq != 16'h0) |-> o_cpu_shared_irq)
    else $error("shared irq missing");
endmodule // msr_supervisor
`default_nettype wire

/* File: verification/msr_carrier_model.sv */
// carrier board model: input supply, power good, power request, buttons, watchdog kicks
// assumes the bench steers it through plain levels changed just after the rising edge
`timescale 1ns/100ps
`default_nettype none
module msr_carrier_model (
  input  wire logic i_ref_clk,
  input  wire logic i_supply_on,
  input  wire logic i_request,
  input  wire logic i_kick_on,
  input  wire logic i_sleep_low,
  input  wire logic i_pwr_low,
  input  wire logic i_en_switched,
  output logic      o_input_5v_ok,
  output logic      o_carrier_power_good,
  output logic      o_power_on_request,
  output var logic  o_sw3v3_good,
  output logic      o_power_button_n,
  output logic      o_sleep_button_n,
  output logic      o_watchdog_kick_n
);
  logic [2:0] pg_q   = 3'h0;
  logic [2:0] kick_q = 3'h0;
  always_ff @(posedge i_ref_clk) begin
    pg_q         <= {pg_q[1:0], i_supply_on};
    o_sw3v3_good <= i_en_switched;
    kick_q       <= kick_q + 3'h1;
  end
  assign o_input_5v_ok = i_supply_on;
  // own rails settle a few cycles after the input supply, so power good lags it
  assign o_carrier_power_good = i_supply_on & pg_q[2];
  assign o_power_on_request = i_request;
  // one low cycle in eight, well inside the shortened watchdog window
  assign o_watchdog_kick_n = ~(i_kick_on & (kick_q == 3'h7));
  assign o_power_button_n = ~i_pwr_low;
  assign o_sleep_button_n = ~i_sleep_low;
endmodule // msr_carrier_model
`default_nettype wire

/* File: verification/msr_supervisor_tb.sv */
// self-checking bench for the module supervisor with shortened delays
// assumes the carrier model drives the board side; the bench owns reset, bus and irqs
`timescale 1ns/100ps
`default_nettype none
module msr_supervisor_tb;
  import msr_pkg::*;
  logic        i_ref_clk, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
  logic [3:0]  i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0, o_rdata;
  logic [47:0] i_rail_level = 48'h738c738c738c;
  logic        i_debug_reset_n = 1'b1, i_reset_button_n = 1'b1;
  logic        i_phy_wake_irq_n = 1'b1, i_phy_irq_n = 1'b1, i_video_irq_n = 1'b1;
  logic [15:0] i_line_irq = 16'h0;
  logic        supply_on = 1'b0, request = 1'b0, kick_on = 1'b1;
  logic        sleep_low = 1'b1, pwr_low = 1'b0;
  wire logic   v5, pg, req, swg, pbn, sbn, kn;
  logic        o_en_3v3_primary, o_en_3v3_switched, o_en_2v5, o_en_1v8_video, o_en_1v8_cpu;
  logic        o_en_1v0, o_en_1v35, o_power_on_reset_in, o_cpu_reset_n, o_phy_reset_n;
  logic        o_exp_reset_n, o_fail_led, o_suspend_power_off_n, o_watchdog_expired;
  logic        o_cpu_shared_irq, l, o_power_event, o_sleep_event;
  logic [2:0]  o_cpu_irq;
  msr_strap_t  straps;
  int          fail_count = 0, n_tests = 0;
  wire logic [7:0] watch = {o_fail_led, o_watchdog_expired, o_suspend_power_off_n,
    o_cpu_reset_n, o_en_1v35, o_en_1v0, o_en_3v3_switched, o_en_3v3_primary};

  msr_carrier_model i_model (.i_ref_clk(i_ref_clk), .i_supply_on(supply_on),
    .i_request(request), .i_kick_on(kick_on), .i_sleep_low(sleep_low), .i_pwr_low(pwr_low),
    .i_en_switched(o_en_3v3_switched), .o_input_5v_ok(v5), .o_carrier_power_good(pg),
    .o_power_on_request(req), .o_sw3v3_good(swg), .o_power_button_n(pbn),
    .o_sleep_button_n(sbn), .o_watchdog_kick_n(kn));

  msr_supervisor #(.RC_DELAY_CYC(4), .BLINK_CYC(4), .WDT_CYC(16)) i_dut (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_input_5v_ok(v5), .i_carrier_power_good(pg),
    .i_power_on_request(req), .i_sw3v3_good(swg), .i_rail_level(i_rail_level),
    .i_debug_reset_n(i_debug_reset_n), .i_reset_button_n(i_reset_button_n),
    .i_power_button_n(pbn), .i_sleep_button_n(sbn), .i_watchdog_kick_n(kn),
    .i_phy_wake_irq_n(i_phy_wake_irq_n), .i_phy_irq_n(i_phy_irq_n),
    .i_video_irq_n(i_video_irq_n), .i_line_irq(i_line_irq), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_en_3v3_primary(o_en_3v3_primary), .o_en_3v3_switched(o_en_3v3_switched),
    .o_en_2v5(o_en_2v5), .o_en_1v8_video(o_en_1v8_video), .o_en_1v8_cpu(o_en_1v8_cpu),
    .o_en_1v0(o_en_1v0), .o_en_1v35(o_en_1v35), .o_power_on_reset_in(o_power_on_reset_in),
    .o_cpu_reset_n(o_cpu_reset_n), .o_phy_reset_n(o_phy_reset_n),
    .o_exp_reset_n(o_exp_reset_n), .o_boot_source_straps(straps), .o_fail_led(o_fail_led),
    .o_suspend_power_off_n(o_suspend_power_off_n), .o_watchdog_expired(o_watchdog_expired),
    .o_cpu_irq(o_cpu_irq), .o_cpu_shared_irq(o_cpu_shared_irq), .o_power_event(o_power_event),
    .o_sleep_event(o_sleep_event));

  initial begin
    i_ref_clk = 1'b0;
    forever #25 i_ref_clk = ~i_ref_clk;
  end

  task automatic final_report;
    if (fail_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask

  // read one word and compare the masked bits
  task automatic rdc(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] m);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata & m, exp);
  endtask

  // bounded wait on one watched output; running out ends the run
  task automatic wait_bit(input int b, input logic v, input int lim);
    int k;
    k = 0;
    while (watch[b] !== v && k < lim) begin
      cyc(1);
      k++;
    end
    chk({31'h0, watch[b]}, {31'h0, v});
    if (watch[b] !== v) final_report();
  endtask

  task automatic press(input logic sleep);
    @(posedge i_ref_clk);
    if (sleep) sleep_low <= 1'b1;
    else pwr_low <= 1'b1;
    cyc(2);
    @(posedge i_ref_clk);
    sleep_low <= 1'b0;
    pwr_low <= 1'b0;
  endtask

  initial begin
    repeat (4) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    cyc(1);
    chk({23'h0, straps}, 32'h040);
    @(posedge i_ref_clk);
    sleep_low <= 1'b0;
    i_rst <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    cyc(1);
    chk({23'h0, straps}, 32'h044);
    chk({30'h0, o_cpu_reset_n, o_suspend_power_off_n}, 32'h1);
    rdc(4'h3, 32'h200, 32'hffffffff);
    rdc(4'hf, 32'h0, 32'hffffffff);
    wr(4'h2, 32'ha000);
    rdc(4'h2, 32'h0, 32'hffffffff);
    chk({31'h0, o_phy_reset_n}, 32'h0);
    @(posedge i_ref_clk);
    supply_on <= 1'b1;
    cyc(1);
    chk({31'h0, o_en_3v3_primary}, 32'h0);
    wait_bit(0, 1'b1, 20);
    chk({31'h0, o_en_3v3_switched}, 32'h0);
    @(posedge i_ref_clk);
    request <= 1'b1;
    wait_bit(1, 1'b1, 10);
    chk({28'h0, o_en_2v5, o_en_1v8_video, o_en_1v8_cpu, o_en_1v0}, 32'he);
    wait_bit(2, 1'b1, 5);
    chk({31'h0, o_en_1v35}, 32'h0);
    wait_bit(3, 1'b1, 5);
    chk({31'h0, o_cpu_reset_n}, 32'h0);
    wait_bit(4, 1'b1, 300);
    rdc(4'h1, 32'h11, 32'h11);
    cyc(40);
    chk({31'h0, o_watchdog_expired}, 32'h0);
    @(posedge i_ref_clk);
    kick_on <= 1'b0;
    cyc(5);
    chk({31'h0, o_watchdog_expired}, 32'h0);
    wait_bit(6, 1'b1, 30);
    rdc(4'h1, 32'h2, 32'h2);
    wr(4'h0, 32'h1);
    cyc(1);
    chk({31'h0, o_watchdog_expired}, 32'h0);
    @(posedge i_ref_clk);
    kick_on <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      @(posedge i_ref_clk);
      {i_video_irq_n, i_phy_irq_n, i_phy_wake_irq_n} <= ~(3'h1 << k);
      cyc(1);
      chk({29'h0, o_cpu_irq}, 32'h1 << k);
    end
    @(posedge i_ref_clk);
    {i_video_irq_n, i_phy_irq_n, i_phy_wake_irq_n} <= 3'h7;
    i_line_irq <= 16'h8000;
    cyc(1);
    chk({28'h0, o_cpu_irq, o_cpu_shared_irq}, 32'h1);
    wr(4'h2, 32'ha000);
    cyc(1);
    chk({30'h0, o_phy_reset_n, o_exp_reset_n}, 32'h3);
    wr(4'h2, 32'h8000);
    cyc(1);
    chk({30'h0, o_phy_reset_n, o_exp_reset_n}, 32'h2);
    wr(4'h2, 32'h2000);
    cyc(1);
    chk({30'h0, o_phy_reset_n, o_exp_reset_n}, 32'h1);
    @(posedge i_ref_clk);
    i_debug_reset_n <= 1'b0;
    cyc(1);
    chk({30'h0, o_cpu_reset_n, o_power_on_reset_in}, 32'h0);
    @(posedge i_ref_clk);
    i_debug_reset_n <= 1'b1;
    i_reset_button_n <= 1'b0;
    cyc(1);
    chk({29'h0, o_cpu_reset_n, o_power_on_reset_in, o_exp_reset_n}, 32'h2);
    @(posedge i_ref_clk);
    i_reset_button_n <= 1'b1;
    cyc(1);
    chk({30'h0, o_cpu_reset_n, o_exp_reset_n}, 32'h2);
    press(1'b0);
    cyc(2);
    chk({31'h0, o_power_event}, 32'h1);
    rdc(4'h1, 32'h4, 32'h4);
    rdc(4'h1, 32'h0, 32'h4);
    press(1'b1);
    wait_bit(5, 1'b0, 6);
    chk({31'h0, o_en_3v3_switched}, 32'h0);
    chk({31'h0, o_sleep_event}, 32'h1);
    rdc(4'h1, 32'h8, 32'h8);
    rdc(4'h0, 32'h2, 32'h2);
    press(1'b1);
    wait_bit(5, 1'b1, 6);
    @(posedge i_ref_clk);
    i_rail_level <= 48'h728c738c738c;
    wait_bit(4, 1'b0, 400);
    cyc(3);
    l = o_fail_led;
    wait_bit(7, ~l, 10);
    wait_bit(7, l, 10);
    rdc(4'h1, 32'h0, 32'h11);
    final_report();
  end
endmodule // msr_supervisor_tb
`default_nettype wire
